// [bench/capture_monitor.sv]
// port checker for the input capture channel
// assumes one pclk domain and the constants of capture_params.svh
`timescale 1ns/100ps
`include "capture_params.svh"
module capture_monitor #(
  parameter int ADDR_W = 14
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic capture_pin, // external pin
  input wire logic irq, // interrupt
  input wire logic wake_req // wake pulse
);
  localparam logic [13:0] A_BUF = {`BUF_IDX, 2'b00};
  localparam logic [13:0] A_CON = {`CON_IDX, 2'b00};
  logic rd_acc;
  logic mapped;
  // -----------------------------------------
  // read decode; address is held through access
  // -----------------------------------------
  assign rd_acc = psel && penable && pready && !pwrite;
  assign mapped = paddr inside {A_BUF, A_CON, {`STAT_IDX, 2'b00},
    {`MASK_IDX, 2'b00}};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_ready_acc; pready |-> psel && penable; endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("stray pready");
  property p_err; psel && !penable && !mapped |=> pslverr && prdata == 0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_quiet; $rose(presetn) |-> !irq && !wake_req; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs after reset");
  property p_pulse; wake_req |=> !wake_req; endproperty
  a_pulse: assert property (p_pulse) else $error("wake too long");
  property p_nowake; !capture_pin [*8] |=> !wake_req; endproperty
  a_nowake: assert property (p_nowake) else $error("no edge wake");
  property p_upper; rd_acc && paddr == A_BUF |-> prdata[31:16] == 0;
  endproperty
  a_upper: assert property (p_upper) else $error("word too wide");
  property p_both;
    rd_acc && paddr == A_CON && prdata[2:0] == 3'b001 |-> !prdata[`OVF_BIT];
  endproperty
  a_both: assert property (p_both) else $error("overflow in both");
  property p_ovf;
    rd_acc && paddr == A_CON && prdata[`OVF_BIT] |-> prdata[`BNE_BIT];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow but empty");
endmodule

bind input_capture_channel capture_monitor #(.ADDR_W(ADDR_W)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .capture_pin(capture_pin), .irq(irq),
  .wake_req(wake_req));

// [bench/capture_source.sv]
// model of the external signal on the capture pin
// assumes the bench asks for a level; the pin follows one clock later
`timescale 1ns/100ps
module capture_source (
  input wire logic pclk, // bench clock
  input wire logic level_req, // level asked for
  output logic capture_pin // driven pin
);
  // ------------------------------------------
  // retimed source: clean edges, no glitches
  // ------------------------------------------
  always_ff @(posedge pclk) begin
    capture_pin <= level_req;
  end
endmodule

// [bench/tb.sv]
// self-checking bench for the input capture channel over apb
// assumes capture_source drives the pin and the checker is bound in
`timescale 1ns/100ps
`include "capture_params.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb
  import capture_pkg::*;
;
  localparam logic [13:0] A_BUF = {`BUF_IDX, 2'b00};
  localparam logic [13:0] A_CON = {`CON_IDX, 2'b00};
  localparam logic [13:0] A_ST = {`STAT_IDX, 2'b00};
  localparam logic [13:0] A_MSK = {`MASK_IDX, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic level_req, capture_pin, cpu_sleep, cpu_idle, wake_req, err_seen;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic [15:0] timer_a_count, timer_b_count;
  logic [7:0] wake_cnt = 8'h0;
  logic [7:0] wake_base;
  mode_e m;
  int fail_count, checks, i, k, n;

  input_capture_channel i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .timer_a_count(timer_a_count),
    .timer_b_count(timer_b_count), .cpu_sleep(cpu_sleep),
    .cpu_idle(cpu_idle), .irq(irq), .wake_req(wake_req));
  capture_source i_src (.pclk(pclk), .level_req(level_req),
    .capture_pin(capture_pin));

  // ------------------------------------------
  // clock, wake pulse counter, hang guard
  // ------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (wake_req === 1'b1) wake_cnt <= wake_cnt + 8'h1;
  end
  initial begin
    #300000;
    fail_count++;
    results();
  end

  // ------------------------------------------
  // apb master, pin pulses, verdict
  // ------------------------------------------
  // request held until pready is seen, so slow answers are fine too
  task automatic apb(input logic wr, input logic [13:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string s, input logic [13:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(s, e, rd_val)
  endtask
  // timers hold still over the pulse, so either edge sees v on timer b and the inverse of v on timer a
  task automatic pulse(input logic [15:0] v);
    timer_b_count <= v;
    timer_a_count <= ~v;
    level_req <= 1'b1;
    repeat (8) @(posedge pclk);
    level_req <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------
  // test sequence
  // ------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, level_req, cpu_sleep, cpu_idle} = 0;
    {paddr, pwdata, timer_a_count, timer_b_count} = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk("control", A_CON, 32'h0);
    rchk("status", A_ST, 32'h0);
    rchk("mask", A_MSK, 32'h0);
    apb(1'b0, A_BUF + 14'h4, 32'h0);
    `CHK("unmapped", 1'b1, err_seen)
    $display("test reset done");
    apb(1'b1, A_MSK, 32'h1);
    apb(1'b1, A_CON, 32'(MODE_RISE));
    for (i = 0; i < 6; i++) pulse(16'h1000 + 16'(i));
    rchk("overflow", A_CON, 32'h1B);
    `CHK("irq set", 1'b1, irq)
    rchk("fifo", A_BUF, 32'h1000);
    pulse(16'h1111);
    for (i = 1; i < 4; i++) rchk("fifo", A_BUF, 32'h1000 + i);
    rchk("drained", A_CON, 32'h3);
    apb(1'b1, A_ST, 32'h7);
    rchk("w1c", A_ST, 32'h0);
    `CHK("irq clear", 1'b0, irq)
    apb(1'b1, A_CON, 32'h80 | 32'(MODE_FALL));
    pulse(16'h2345);
    rchk("one capture", A_CON, 32'h8A);
    rchk("timer a", A_BUF, 32'h0000DCBA);
    $display("test capture done");
    for (k = 0; k < 2; k++) begin
      m = k ? MODE_RISE16 : MODE_RISE4;
      n = k ? 16 : 4;
      apb(1'b1, A_CON, 32'(m));
      repeat (n - 1) pulse(16'h0);
      apb(1'b1, A_CON, 32'h0);
      apb(1'b1, A_CON, 32'(m));
      repeat (n - 1) pulse(16'h0);
      rchk("prescale", A_CON, 32'(m));
      pulse(16'h4000);
      rchk("nth edge", A_BUF, 32'h4000);
    end
    // a reset in mid-count must leave the prescaler at zero
    apb(1'b1, A_CON, 32'(MODE_RISE4));
    repeat (3) pulse(16'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, A_MSK, 32'h1);
    apb(1'b1, A_CON, 32'(MODE_RISE4));
    repeat (3) pulse(16'h0);
    rchk("reset prescale", A_CON, 32'(MODE_RISE4));
    pulse(16'h4444);
    rchk("reset nth", A_BUF, 32'h4444);
    $display("test prescale done");
    apb(1'b1, A_CON, 32'h61);
    apb(1'b1, A_ST, 32'h7);
    level_req <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk("rise flag", A_ST, 32'h1);
    apb(1'b1, A_ST, 32'h1);
    level_req <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk("fall flag", A_ST, 32'h1);
    repeat (2) pulse(16'h5000);
    rchk("no overflow", A_CON, 32'h69);
    repeat (4) apb(1'b0, A_BUF, 32'h0);
    rchk("empty", A_CON, 32'h61);
    apb(1'b1, A_CON, 32'h0);
    apb(1'b1, A_CON, 32'h23);
    apb(1'b1, A_ST, 32'h7);
    pulse(16'h0);
    rchk("first event", A_ST, 32'h0);
    pulse(16'h0);
    rchk("second event", A_ST, 32'h1);
    repeat (2) apb(1'b0, A_BUF, 32'h0);
    $display("test events done");
    apb(1'b1, A_CON, 32'(MODE_IRQ));
    for (k = 0; k < 2; k++) begin
      cpu_sleep <= (k == 0);
      cpu_idle <= (k == 1);
      wake_base = wake_cnt;
      pulse(16'h6000);
      `CHK("wake", wake_base + 8'h1, wake_cnt)
      rchk("pin only", A_CON, 32'h7);
    end
    // idle keeps capturing unless stop-in-idle; sleep never captures
    apb(1'b1, A_CON, 32'(MODE_RISE));
    pulse(16'h7000);
    rchk("idle capture", A_CON, 32'hB);
    apb(1'b1, A_CON, 32'h2003);
    pulse(16'h7001);
    rchk("idle stop", A_CON, 32'h200B);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    apb(1'b1, A_CON, 32'(MODE_RISE));
    pulse(16'h7002);
    rchk("sleep halt", A_BUF, 32'h7000);
    rchk("sleep empty", A_CON, 32'h3);
    cpu_sleep <= 1'b0;
    apb(1'b1, A_CON, 32'h6);
    pulse(16'h7003);
    rchk("reserved", A_CON, 32'h6);
    $display("test wake done");
    results();
  end
endmodule

// [inc/capture_params.svh]
// constants for the input capture channel: offsets, fields, counts
// assumes a 32-bit apb slave with one aligned word per register
`ifndef CAPTURE_PARAMS_SVH
`define CAPTURE_PARAMS_SVH

// register indices; byte address is four times the index
`define BUF_IDX 12'h140
`define CON_IDX 12'h142
`define STAT_IDX 12'h148
`define MASK_IDX 12'h149

// control word fields
`define MODE_LSB 0
`define BNE_BIT 3
`define OVF_BIT 4
`define EPI_LSB 5
`define TSEL_BIT 7
`define SIDL_BIT 13
`define CON_RESET 16'h0000

// interrupt status and mask bits
`define ST_CAP 0
`define ST_OVF 1
`define ST_WAKE 2
`define ST_W 3
`define ST_RESET 3'h0
`define MASK_RESET 3'h0

// prescaler terminal counts
`define PRESC_4 4'h3
`define PRESC_16 4'hF

`endif

// [inc/capture_pkg.sv]
// types for the input capture channel
// assumes capture_params.svh supplies the numeric constants
package capture_pkg;

  // capture mode field encodings
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_BOTH = 3'b001,
    MODE_FALL = 3'b010,
    MODE_RISE = 3'b011,
    MODE_RISE4 = 3'b100,
    MODE_RISE16 = 3'b101,
    MODE_RSV = 3'b110,
    MODE_IRQ = 3'b111
  } mode_e;

endpackage

// [rtl/capture_fifo.sv]
// shifting capture buffer: oldest word always sits at entry zero
// assumes the caller never pushes when full and never pops when empty
`timescale 1ns/100ps
module capture_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, low
  input wire logic push, // store din at tail
  input wire logic pop, // drop head, shift forward
  input wire logic [WIDTH-1:0] din, // word to store
  output logic [WIDTH-1:0] head, // oldest word
  output logic [$clog2(DEPTH+1)-1:0] count, // words held
  output logic full, // count equals depth
  output logic empty // no words held
);

  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("capture_fifo: depth below two or zero width");
  end

  // ----------------------------------------
  // shift and store
  // ----------------------------------------
  // a read moves every word one place toward the head
  always_comb begin
    logic [CW-1:0] tail;
    tail = st.cnt;
    next_st = st;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.mem[i] = st.mem[i+1];
      end
      tail = st.cnt - CW'(1);
    end
    if (push) begin
      next_st.mem[tail] = din;
    end
    next_st.cnt = tail + CW'(push);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head = st.mem[0];
  assign count = st.cnt;
  assign full = (st.cnt == CW'(DEPTH));
  assign empty = (st.cnt == '0);

endmodule

// [rtl/input_capture_channel.sv]
// one input capture channel with an apb register slave
// assumes pin, timer counts and cpu power states are synchronous
// to pclk except capture_pin, which is synchronised here
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`include "capture_params.svh"
module input_capture_channel
  import capture_pkg::*;
#(
  parameter int TIMER_W = 16,
  parameter int FIFO_DEPTH = 4,
  parameter int ADDR_W = 14
) (
  input wire logic pclk, // bus and capture clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic capture_pin, // external capture input
  input wire logic [TIMER_W-1:0] timer_a_count, // first timer
  input wire logic [TIMER_W-1:0] timer_b_count, // second timer
  input wire logic cpu_sleep, // cpu in sleep
  input wire logic cpu_idle, // cpu in idle
  output logic irq, // level interrupt
  output logic wake_req // one-cycle wake pulse
);

  localparam int CW = $clog2(FIFO_DEPTH+1);

  if (TIMER_W < 1 || TIMER_W > 32) begin : g_bad_w
    $error("input_capture_channel: timer width must be 1 to 32");
  end
  if (FIFO_DEPTH < 2) begin : g_bad_d
    $error("input_capture_channel: buffer depth below two");
  end
  if (ADDR_W < 14) begin : g_bad_a
    $error("input_capture_channel: address too narrow for map");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic pin_q;
    mode_e mode;
    logic [1:0] events_per_irq;
    logic timebase_select;
    logic stop_in_idle;
    logic [3:0] presc;
    logic [1:0] epi_cnt;
    logic buffer_overflow;
    logic [`ST_W-1:0] status;
    logic [`ST_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wake_req;
  } chan_s;

  chan_s st;
  chan_s next_st;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // same compare used for read data, error and write strobes
  function automatic logic addr_hit(logic [ADDR_W-1:0] a,
                                    logic [11:0] idx);
    addr_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    mapped = addr_hit(a, `BUF_IDX) || addr_hit(a, `CON_IDX) ||
             addr_hit(a, `STAT_IDX) || addr_hit(a, `MASK_IDX);
  endfunction

  // ----------------------------------------
  // capture buffer
  // ----------------------------------------
  logic fifo_push;
  logic fifo_pop;
  logic [TIMER_W-1:0] fifo_din;
  logic [TIMER_W-1:0] fifo_head;
  logic [CW-1:0] fifo_count;
  logic fifo_full;
  logic fifo_empty;

  // private per-channel buffer
  capture_fifo #(
    .WIDTH(TIMER_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .push(fifo_push),
    .pop(fifo_pop),
    .din(fifo_din),
    .head(fifo_head),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // ----------------------------------------
  // control word image
  // ----------------------------------------
  // not-empty is live buffer state, so it drops on the last read
  function automatic logic [15:0] con_word(chan_s s, logic bne);
    logic [15:0] w;
    w = `CON_RESET;
    w[`MODE_LSB +: 3] = s.mode;
    w[`BNE_BIT] = bne;
    w[`OVF_BIT] = s.buffer_overflow;
    w[`EPI_LSB +: 2] = s.events_per_irq;
    w[`TSEL_BIT] = s.timebase_select;
    w[`SIDL_BIT] = s.stop_in_idle;
    con_word = w;
  endfunction

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic halted;
    logic edge_evt;
    logic cap_evt;
    logic pin_irq;
    logic irq_evt;
    logic ovf_evt;
    logic wr_done;
    logic rd_done;
    logic setup;
    logic [`ST_W-1:0] st_set;
    logic [`ST_W-1:0] st_clr;
    rise = 1'b0;
    fall = 1'b0;
    halted = 1'b0;
    edge_evt = 1'b0;
    cap_evt = 1'b0;
    pin_irq = 1'b0;
    irq_evt = 1'b0;
    ovf_evt = 1'b0;
    wr_done = 1'b0;
    rd_done = 1'b0;
    setup = 1'b0;
    st_set = '0;
    st_clr = '0;
    next_st = st;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;

    // two flops, then a third for the edge compare
    next_st.sync1 = capture_pin;
    next_st.sync2 = st.sync1;
    next_st.pin_q = st.sync2;
    rise = st.sync2 & ~st.pin_q;
    fall = ~st.sync2 & st.pin_q;

    // sleep, or idle with stop-in-idle, freezes capture
    halted = cpu_sleep | (cpu_idle & st.stop_in_idle);

    // edge selection per mode
    case (st.mode)
      MODE_BOTH: edge_evt = rise | fall;
      MODE_FALL: edge_evt = fall;
      MODE_RISE: edge_evt = rise;
      MODE_RISE4: edge_evt = rise;
      MODE_RISE16: edge_evt = rise;
      default: edge_evt = 1'b0;
    endcase

    // prescaler: only 4:1 and 16:1 modes count rising edges
    if (st.mode == MODE_OFF) begin
      next_st.presc = '0;
    end else if (edge_evt && !halted) begin
      if (st.mode == MODE_RISE4) begin
        cap_evt = (st.presc == `PRESC_4);
        next_st.presc = cap_evt ? 4'h0 : st.presc + 4'h1;
      end else if (st.mode == MODE_RISE16) begin
        cap_evt = (st.presc == `PRESC_16);
        next_st.presc = cap_evt ? 4'h0 : st.presc + 4'h1;
      end else begin
        cap_evt = 1'b1;
      end
    end

    // mode 111 is a pin interrupt only, never a capture
    pin_irq = (st.mode == MODE_IRQ) && rise;

    // ----- apb phases -----
    setup = psel & ~penable;
    wr_done = psel & penable & st.pready & pwrite;
    rd_done = psel & penable & st.pready & ~pwrite;

    // read of buffer pops the head; empty reads pop nothing
    fifo_pop = rd_done && addr_hit(paddr, `BUF_IDX) && !fifo_empty;

    // store selected timer count; overflow blocks until drained
    // timebase_select low picks the second timer
    fifo_din = st.timebase_select ? timer_a_count : timer_b_count;
    if (cap_evt) begin
      if (fifo_full) begin
        // every-edge mode drops silently
        ovf_evt = (st.mode != MODE_BOTH);
      end else if (!st.buffer_overflow) begin
        fifo_push = 1'b1;
      end
    end

    // overflow clears once the last buffered word leaves
    if (ovf_evt) begin
      next_st.buffer_overflow = 1'b1;
    end else if (fifo_pop && fifo_count == CW'(1)) begin
      next_st.buffer_overflow = 1'b0;
    end

    // events per interrupt: 1..4 events, ignored in every-edge
    if (cap_evt) begin
      if (st.mode == MODE_BOTH) begin
        irq_evt = 1'b1;
        next_st.epi_cnt = '0;
      end else if (st.epi_cnt == st.events_per_irq) begin
        irq_evt = 1'b1;
        next_st.epi_cnt = '0;
      end else begin
        next_st.epi_cnt = st.epi_cnt + 2'h1;
      end
    end
    if (pin_irq) begin
      irq_evt = 1'b1;
    end

    // wake needs mode 111 and the capture interrupt enabled
    next_st.wake_req = pin_irq && st.mask[`ST_CAP] &&
                       (cpu_sleep || cpu_idle);

    // ----- register writes -----
    if (wr_done && addr_hit(paddr, `CON_IDX)) begin
      next_st.mode = mode_e'(pwdata[`MODE_LSB +: 3]);
      next_st.events_per_irq = pwdata[`EPI_LSB +: 2];
      next_st.timebase_select = pwdata[`TSEL_BIT];
      next_st.stop_in_idle = pwdata[`SIDL_BIT];
      // switching off clears the prescaler and event count
      if (mode_e'(pwdata[`MODE_LSB +: 3]) == MODE_OFF) begin
        next_st.presc = '0;
        next_st.epi_cnt = '0;
      end
    end
    if (wr_done && addr_hit(paddr, `STAT_IDX)) begin
      st_clr = pwdata[`ST_W-1:0];
    end
    if (wr_done && addr_hit(paddr, `MASK_IDX)) begin
      next_st.mask = pwdata[`ST_W-1:0];
    end

    // sticky status; a new event beats a same-cycle clear
    st_set[`ST_CAP] = irq_evt;
    st_set[`ST_OVF] = ovf_evt;
    st_set[`ST_WAKE] = next_st.wake_req;
    next_st.status = (st.status & ~st_clr) | st_set;
    next_st.irq = |(next_st.status & next_st.mask);

    // ----- read data and ready, set up one cycle ahead -----
    // ready rises in the first access cycle: no wait states
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped(paddr);
    if (setup && !pwrite) begin
      if (addr_hit(paddr, `BUF_IDX)) begin
        // head is the oldest word; undefined when empty
        next_st.prdata = {{(32-TIMER_W){1'b0}}, fifo_head};
      end else if (addr_hit(paddr, `CON_IDX)) begin
        next_st.prdata = {16'h0000, con_word(st, !fifo_empty)};
      end else if (addr_hit(paddr, `STAT_IDX)) begin
        next_st.prdata = {{(32-`ST_W){1'b0}}, st.status};
      end else if (addr_hit(paddr, `MASK_IDX)) begin
        next_st.prdata = {{(32-`ST_W){1'b0}}, st.mask};
      end else begin
        next_st.prdata = 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // any reset clears prescaler and all control state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // every output comes straight from a flop
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign wake_req = st.wake_req;

endmodule
